// ### bench/uartc_partner.sv
// Remote serial transceiver model on the far side of the serial pins
`timescale 1ns/100ps
`default_nettype none
module uartc_partner (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic line_i,
  output var  logic line_o
);
  initial line_o = 1'b1;

  // Bits go out from bit 0 upward, start bit first, stop bit leaves the line idle high
  task automatic send(input logic [10:0] bits, input int n, input int cyc);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line_o <= bits[i];
      repeat (cyc - 1) @(posedge clk);
    end
  endtask : send

  task automatic set_level(input logic v);
    @(posedge clk);
    line_o <= v;
  endtask : set_level

  // Waits for a start edge, then samples each bit in its middle on the falling clock edge
  task automatic capture(output logic [10:0] bits, input int n, input int cyc);
    int w;
    bits = '1;
    w = 0;
    while (line_i !== 1'b0 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    repeat (cyc / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_i;
      if (i < n - 1) repeat (cyc) @(negedge clk);
    end
  endtask : capture
endmodule : uartc_partner
`default_nettype wire

// ### bench/uartc_tb_top.sv
// Self-checking bench for the serial port register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module uartc_tb_top;
  logic                      clk;
  logic                      arst_n;
  uartc_pkg::uartc_bus_req_t bus_req;
  logic [7:0]                reg_rdata;
  logic                      timer1_ovf;
  logic                      serial_in_pin;
  wire logic                 tx_line;
  logic                      tx_o;
  logic                      tx_oe_n;
  logic                      uart_irq;
  int                        miscompares;
  int                        num_checks;
  int                        cycles;

  // Released transmit pin floats high through a pull-up
  assign tx_line = tx_oe_n ? 1'b1 : tx_o;

  uartc_top uut (
    .clk                 (clk),
    .arst_n              (arst_n),
    .bus_req             (bus_req),
    .reg_rdata           (reg_rdata),
    .timer1_ovf          (timer1_ovf),
    .serial_in_pin       (serial_in_pin),
    .serial_out_pin_i    (tx_line),
    .serial_out_pin_o    (tx_o),
    .serial_out_pin_oe_n (tx_oe_n),
    .uart_irq            (uart_irq)
  );

  uartc_partner far_end (
    .clk    (clk),
    .line_i (tx_line),
    .line_o (serial_in_pin)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Timer overflow every second cycle
  always @(posedge clk) begin
    timer1_ovf <= ~timer1_ovf;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic reg_is(input logic [7:0] a, input logic [7:0] ev);
    logic [7:0] d;
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
    `CHK(d, ev);
  endtask : reg_is

  task automatic pins_are(input logic [1:0] ev);
    repeat (2) @(posedge clk);
    #1;
    `CHK({tx_o, tx_oe_n}, ev);
  endtask : pins_are

  task automatic t_disabled();
    `CHK(tx_oe_n, 1'b1);
    reg_is(8'h98, 8'h00);
    wr(8'hD8, 8'h80);
    wr(8'h87, 8'h80);
    wr(8'h99, 8'h55);
    reg_is(8'hD8, 8'h00);
    reg_is(8'h87, 8'h00);
    reg_is(8'h99, 8'h00);
    reg_is(8'h01, 8'h00);
  endtask : t_disabled

  task automatic t_pins();
    wr(8'h98, 8'h10);
    reg_is(8'h98, 8'h10);
    wr(8'hF9, 8'h20);
    pins_are(2'b00);
    wr(8'h80, 8'h20);
    wr(8'hE4, 8'h01);
    pins_are(2'b01);
    wr(8'hE4, 8'h00);
    pins_are(2'b10);
    far_end.set_level(1'b0);
    reg_is(8'h80, 8'h20);
    far_end.set_level(1'b1);
    reg_is(8'h80, 8'h60);
    repeat (30) @(posedge clk);
  endtask : t_pins

  task automatic t_tx();
    logic [10:0] got;
    logic [7:0]  d;
    logic [7:0]  sc;
    int          cyc [4] = '{12, 32, 64, 64};
    logic [7:0]  pc [4] = '{8'h80, 8'h80, 8'h00, 8'h00};
    logic [7:0]  bd [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
    wr(8'hD8, 8'hFF);
    reg_is(8'hD8, 8'h80);
    wr(8'hAA, 8'hFF);
    wr(8'hBA, 8'h03);
    for (int m = 0; m < 4; m++) begin
      d = 8'h35 + 8'(m * 17);
      sc = 8'(m << 6) | 8'h10 | (m[0] ? 8'h08 : 8'h00);
      wr(8'h98, sc);
      wr(8'h87, pc[m]);
      wr(8'hD8, bd[m]);
      wr(8'h99, d);
      far_end.capture(got, (m > 1) ? 11 : 10, cyc[m]);
      `CHK(got, (m > 1) ? {1'b1, m[0], d, 1'b0} : {2'b11, d, 1'b0});
      reg_is(8'h98, sc | 8'h02);
      repeat (cyc[m]) @(posedge clk);
    end
  endtask : t_tx

  task automatic rx_one(input logic [7:0] sc, input logic [8:0] v, input logic [7:0] ev_sc,
                        input logic [7:0] ev_buf);
    wr(8'h98, sc);
    far_end.send({1'b1, v, 1'b0}, 11, 64);
    reg_is(8'h98, ev_sc);
    reg_is(8'h99, ev_buf);
  endtask : rx_one

  task automatic t_rx();
    rx_one(8'h90, 9'h13C, 8'h95, 8'h3C);
    wr(8'hA8, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    `CHK(uart_irq, 1'b0);
    wr(8'hA8, 8'h90);
    repeat (2) @(posedge clk);
    #1;
    `CHK(uart_irq, 1'b1);
    repeat (200) @(posedge clk);
    reg_is(8'h98, 8'h95);
    wr(8'h98, 8'h90);
    repeat (2) @(posedge clk);
    #1;
    `CHK(uart_irq, 1'b0);
    rx_one(8'hB0, 9'h0C3, 8'hB0, 8'hC3);
    rx_one(8'hB0, 9'h15A, 8'hB5, 8'h5A);
    rx_one(8'hF0, 9'h15A, 8'hF5, 8'h5A);
    wr(8'hE4, 8'h02);
    rx_one(8'h90, 9'h1A5, 8'h90, 8'h5A);
  endtask : t_rx

  initial begin
    arst_n = 1'b0;
    bus_req = '0;
    timer1_ovf = 1'b0;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_disabled();
    t_pins();
    t_tx();
    t_rx();
    stop_test();
  end
endmodule : uartc_tb_top
`default_nettype wire

// ### hdl/uartc_pkg.sv
// Register map, field layout, timing counts and types of the serial port block
`default_nettype none
package uartc_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PORT0_PIN_LATCH  = 8'h80;
  localparam logic [7:0] ADDR_POWER_BAUD_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL   = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER    = 8'h99;
  localparam logic [7:0] ADDR_IRQ_ENABLE_MAIN  = 8'hA8;
  localparam logic [7:0] ADDR_BAUD_RELOAD_LOW  = 8'hAA;
  localparam logic [7:0] ADDR_BAUD_RELOAD_HIGH = 8'hBA;
  localparam logic [7:0] ADDR_SERIAL_CTRL_EXT  = 8'hD8;
  localparam logic [7:0] ADDR_PIN_DRAIN_CTRL   = 8'hE4;
  localparam logic [7:0] ADDR_PIN_DIR_CTRL     = 8'hF9;

  // Field positions
  localparam int MODE_POS        = 6;
  localparam int MP_EN_POS       = 5;
  localparam int UART_EN_POS     = 4;
  localparam int TX_NINTH_POS    = 3;
  localparam int RX_NINTH_POS    = 2;
  localparam int TX_DONE_POS     = 1;
  localparam int RX_DONE_POS     = 0;
  localparam int BAUD_SRC_POS    = 7;
  localparam int BAUD_DOUBLE_POS = 7;
  localparam int GLOBAL_IRQ_POS  = 7;
  localparam int UART_IRQ_POS    = 4;
  localparam int RX_PIN_POS      = 6;
  localparam int TX_PIN_POS      = 5;
  localparam int RX_DRAIN_POS    = 1;
  localparam int TX_DRAIN_POS    = 0;

  // Reset values
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [9:0] RELOAD_RESET = 10'h000;

  // Ticks per bit: mode 0 runs 12 one-cycle ticks, the others 16 ticks
  localparam logic [3:0]  TICK_LAST_M0  = 4'hB;
  localparam logic [3:0]  TICK_LAST     = 4'hF;
  localparam logic [3:0]  HALF_LAST_M0  = 4'h5;
  localparam logic [3:0]  HALF_LAST     = 4'h7;
  // Tick divisors: 16 x 4 = 64 and 16 x 2 = 32 cycles per bit
  localparam logic [12:0] MODE0_DIV     = 13'h0001;
  localparam logic [12:0] TICK_DIV_SLOW = 13'h0004;
  localparam logic [12:0] TICK_DIV_FAST = 13'h0002;
  // Timer overflows per tick: 32 or 16 overflows per bit
  localparam logic [12:0] T1_DIV_SLOW   = 13'h0002;
  localparam logic [12:0] T1_DIV_FAST   = 13'h0001;
  localparam logic [12:0] RELOAD_SPAN   = 13'h0400;
  localparam logic [3:0]  DATA_BITS_8   = 4'h8;
  localparam logic [3:0]  DATA_BITS_9   = 4'h9;

  typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} uartc_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uartc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uartc_rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uartc_bus_req_t;

  typedef struct packed {
    logic [7:0]      scon;
    logic            bd;
    logic [7:0]      power_baud_control;
    logic [9:0]      reload;
    logic [7:0]      rx_buf;
    logic [7:0]      ien;
    logic [7:0]      p0;
    logic [7:0]      p0oc;
    logic [7:0]      p0m;
    logic [7:0]      rd_data;
    logic [12:0]     presc;
    uartc_tx_state_t tx_state;
    logic [8:0]      tx_shift;
    logic [3:0]      tx_bits;
    logic [3:0]      tx_tick;
    uartc_rx_state_t rx_state;
    logic [8:0]      rx_shift;
    logic [3:0]      rx_bits;
    logic [3:0]      rx_tick;
    logic            rx_prev;
    logic            irq;
    logic            tx_out;
    logic            tx_oe_n;
  } uartc_state_t;

  // All zero except the transmit pin enable, which starts released
  localparam uartc_state_t STATE_RESET = uartc_state_t'(1);

endpackage : uartc_pkg

`default_nettype wire

// ### hdl/uartc_top.sv
// Serial port register block with four framing modes and port pin control
`timescale 1ns/100ps
`default_nettype none

module uartc_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire uartc_pkg::uartc_bus_req_t bus_req,
  output logic [7:0]                     reg_rdata,
  // Baud source from the timer
  input  wire logic                      timer1_ovf,
  // Serial pins
  input  wire logic                      serial_in_pin,
  input  wire logic                      serial_out_pin_i,
  output logic                           serial_out_pin_o,
  output logic                           serial_out_pin_oe_n,
  // Interrupt request
  output logic                           uart_irq
);

  uartc_pkg::uartc_state_t st_ff;
  uartc_pkg::uartc_state_t nxt_st;
  uartc_pkg::uartc_mode_t  mode;
  logic                    en;
  logic                    nine;
  logic                    baud_double;
  logic                    use_t1;
  logic                    src;
  logic                    tick;
  logic [12:0]             span;
  logic [12:0]             div_m2;
  logic [12:0]             div;
  logic [3:0]              bit_last;
  logic [3:0]              half_last;
  logic [3:0]              nbits;
  logic                    rx_line;
  logic                    tx_line;
  logic                    tx_level;
  logic                    tx_end;
  logic                    rx_end;
  logic                    rx_half;
  logic                    rx_ninth;
  logic                    tx_set;
  logic                    rx_set;
  logic                    buf_wr;

  always_comb begin : next_state
    nxt_st         = st_ff;
    nxt_st.rd_data = uartc_pkg::REG_RESET;
    en             = st_ff.scon[uartc_pkg::UART_EN_POS];
    mode           = uartc_pkg::uartc_mode_t'(st_ff.scon[uartc_pkg::MODE_POS +: 2]);
    nine           = (mode == uartc_pkg::MODE2) || (mode == uartc_pkg::MODE3);
    baud_double           = st_ff.power_baud_control[uartc_pkg::BAUD_DOUBLE_POS];
    use_t1         = ((mode == uartc_pkg::MODE1) || (mode == uartc_pkg::MODE3)) && !st_ff.bd;
    span           = uartc_pkg::RELOAD_SPAN - {3'h0, st_ff.reload};
    div_m2         = baud_double ? uartc_pkg::TICK_DIV_FAST : uartc_pkg::TICK_DIV_SLOW;
    unique case (mode)
      uartc_pkg::MODE0: div = uartc_pkg::MODE0_DIV;
      uartc_pkg::MODE2: div = div_m2;
      uartc_pkg::MODE1,
      uartc_pkg::MODE3: begin
        if (use_t1) begin
          div = baud_double ? uartc_pkg::T1_DIV_FAST : uartc_pkg::T1_DIV_SLOW;
        end else begin
          div = 13'(span * div_m2);
        end
      end
    endcase
    src       = use_t1 ? timer1_ovf : 1'b1;
    tick      = en && src && (st_ff.presc >= div - 13'h0001);
    bit_last  = (mode == uartc_pkg::MODE0) ? uartc_pkg::TICK_LAST_M0 : uartc_pkg::TICK_LAST;
    half_last = (mode == uartc_pkg::MODE0) ? uartc_pkg::HALF_LAST_M0 : uartc_pkg::HALF_LAST;
    nbits     = nine ? uartc_pkg::DATA_BITS_9 : uartc_pkg::DATA_BITS_8;
    rx_line   = serial_in_pin | st_ff.p0oc[uartc_pkg::RX_DRAIN_POS];
    tx_end    = tick && (st_ff.tx_tick == bit_last);
    rx_end    = tick && (st_ff.rx_tick == bit_last);
    rx_half   = tick && (st_ff.rx_tick == half_last);
    rx_ninth  = nine ? st_ff.rx_shift[8] : rx_line;
    tx_set    = 1'b0;
    rx_set    = 1'b0;
    buf_wr    = bus_req.wr && (bus_req.addr == uartc_pkg::ADDR_SERIAL_BUFFER) && en;

    // Baud prescaler is cleared to zero and held there while the port is disabled
    if (!en || tick) begin
      nxt_st.presc = 13'h0000;
    end else if (src) begin
      nxt_st.presc = st_ff.presc + 13'h0001;
    end

    // Register writes; gated registers ignore writes while disabled
    if (bus_req.wr) begin
      case (bus_req.addr)
        uartc_pkg::ADDR_SERIAL_CONTROL:   nxt_st.scon = bus_req.wdata;
        uartc_pkg::ADDR_SERIAL_CTRL_EXT:  if (en) nxt_st.bd = bus_req.wdata[uartc_pkg::BAUD_SRC_POS];
        uartc_pkg::ADDR_POWER_BAUD_CTRL: begin
          nxt_st.power_baud_control = bus_req.wdata;
          if (!en) nxt_st.power_baud_control[uartc_pkg::BAUD_DOUBLE_POS] = baud_double;
        end
        uartc_pkg::ADDR_BAUD_RELOAD_HIGH: if (en) nxt_st.reload[9:8] = bus_req.wdata[1:0];
        uartc_pkg::ADDR_BAUD_RELOAD_LOW:  if (en) nxt_st.reload[7:0] = bus_req.wdata;
        uartc_pkg::ADDR_IRQ_ENABLE_MAIN:  nxt_st.ien  = bus_req.wdata;
        uartc_pkg::ADDR_PORT0_PIN_LATCH:  nxt_st.p0   = bus_req.wdata;
        uartc_pkg::ADDR_PIN_DRAIN_CTRL:   nxt_st.p0oc = bus_req.wdata;
        uartc_pkg::ADDR_PIN_DIR_CTRL:     nxt_st.p0m  = bus_req.wdata;
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle only
    if (bus_req.rd) begin
      case (bus_req.addr)
        uartc_pkg::ADDR_SERIAL_CONTROL:   nxt_st.rd_data = st_ff.scon;
        uartc_pkg::ADDR_SERIAL_CTRL_EXT:  nxt_st.rd_data = {st_ff.bd & en, 7'h00};
        uartc_pkg::ADDR_SERIAL_BUFFER:    nxt_st.rd_data = en ? st_ff.rx_buf : 8'h00;
        uartc_pkg::ADDR_POWER_BAUD_CTRL: begin
          nxt_st.rd_data = st_ff.power_baud_control;
          nxt_st.rd_data[uartc_pkg::BAUD_DOUBLE_POS] = baud_double & en;
        end
        uartc_pkg::ADDR_BAUD_RELOAD_HIGH: nxt_st.rd_data = en ? {6'h00, st_ff.reload[9:8]} : 8'h00;
        uartc_pkg::ADDR_BAUD_RELOAD_LOW:  nxt_st.rd_data = en ? st_ff.reload[7:0] : 8'h00;
        uartc_pkg::ADDR_IRQ_ENABLE_MAIN:  nxt_st.rd_data = st_ff.ien;
        uartc_pkg::ADDR_PORT0_PIN_LATCH: begin
          nxt_st.rd_data = st_ff.p0;
          nxt_st.rd_data[uartc_pkg::RX_PIN_POS] = serial_in_pin;
          if (!st_ff.p0m[uartc_pkg::TX_PIN_POS]) begin
            nxt_st.rd_data[uartc_pkg::TX_PIN_POS] = serial_out_pin_i;
          end
        end
        uartc_pkg::ADDR_PIN_DRAIN_CTRL:   nxt_st.rd_data = st_ff.p0oc;
        uartc_pkg::ADDR_PIN_DIR_CTRL:     nxt_st.rd_data = st_ff.p0m;
        default:                          nxt_st.rd_data = 8'h00;
      endcase
    end

    // Transmitter
    if (tick && (st_ff.tx_state != uartc_pkg::TX_IDLE)) begin
      nxt_st.tx_tick = tx_end ? 4'h0 : st_ff.tx_tick + 4'h1;
    end
    unique case (st_ff.tx_state)
      uartc_pkg::TX_IDLE: begin
        if (buf_wr) begin
          nxt_st.tx_shift = {st_ff.scon[uartc_pkg::TX_NINTH_POS], bus_req.wdata};
          nxt_st.tx_state = uartc_pkg::TX_START;
          nxt_st.tx_tick  = 4'h0;
          nxt_st.tx_bits  = 4'h0;
        end
      end
      uartc_pkg::TX_START: if (tx_end) nxt_st.tx_state = uartc_pkg::TX_DATA;
      uartc_pkg::TX_DATA: begin
        if (tx_end) begin
          nxt_st.tx_shift = {1'b1, st_ff.tx_shift[8:1]};
          nxt_st.tx_bits  = st_ff.tx_bits + 4'h1;
          if (st_ff.tx_bits == nbits - 4'h1) begin
            nxt_st.tx_state = uartc_pkg::TX_STOP;
            tx_set          = 1'b1;
          end
        end
      end
      uartc_pkg::TX_STOP: if (tx_end) nxt_st.tx_state = uartc_pkg::TX_IDLE;
    endcase

    // Receiver, sampling mid-bit from the start edge
    nxt_st.rx_prev = rx_line;
    if (tick && (st_ff.rx_state != uartc_pkg::RX_IDLE)) begin
      nxt_st.rx_tick = rx_end ? 4'h0 : st_ff.rx_tick + 4'h1;
    end
    unique case (st_ff.rx_state)
      uartc_pkg::RX_IDLE: begin
        if (en && st_ff.rx_prev && !rx_line) begin
          nxt_st.rx_state = uartc_pkg::RX_START;
          nxt_st.rx_tick  = 4'h0;
          nxt_st.rx_bits  = 4'h0;
        end
      end
      uartc_pkg::RX_START: begin
        if (rx_half) begin
          nxt_st.rx_tick  = 4'h0;
          nxt_st.rx_state = rx_line ? uartc_pkg::RX_IDLE : uartc_pkg::RX_DATA;
        end
      end
      uartc_pkg::RX_DATA: begin
        if (rx_end) begin
          nxt_st.rx_shift = {rx_line, st_ff.rx_shift[8:1]};
          nxt_st.rx_bits  = st_ff.rx_bits + 4'h1;
          if (st_ff.rx_bits == nbits - 4'h1) nxt_st.rx_state = uartc_pkg::RX_STOP;
        end
      end
      uartc_pkg::RX_STOP: begin
        if (rx_end) begin
          nxt_st.rx_state = uartc_pkg::RX_IDLE;
          nxt_st.rx_buf   = nine ? st_ff.rx_shift[7:0] : st_ff.rx_shift[8:1];
          rx_set          = !(st_ff.scon[uartc_pkg::MP_EN_POS] && nine && !rx_ninth);
        end
      end
    endcase

    // Port disable halts both engines
    if (!en) begin
      nxt_st.tx_state = uartc_pkg::TX_IDLE;
      nxt_st.rx_state = uartc_pkg::RX_IDLE;
      nxt_st.tx_tick  = 4'h0;
      nxt_st.rx_tick  = 4'h0;
    end

    // Hardware events win over a software write in the same cycle
    if (tx_set) nxt_st.scon[uartc_pkg::TX_DONE_POS] = 1'b1;
    if (rx_end && (st_ff.rx_state == uartc_pkg::RX_STOP)) begin
      nxt_st.scon[uartc_pkg::RX_NINTH_POS] = rx_ninth;
    end
    if (rx_set) nxt_st.scon[uartc_pkg::RX_DONE_POS] = 1'b1;

    // Transmit pin: gated by latch, direction and drive type; open-drain drives low only, push-pull drives both levels
    unique case (st_ff.tx_state)
      uartc_pkg::TX_START: tx_line = 1'b0;
      uartc_pkg::TX_DATA:  tx_line = st_ff.tx_shift[0];
      uartc_pkg::TX_IDLE,
      uartc_pkg::TX_STOP:  tx_line = 1'b1;
    endcase
    tx_level       = st_ff.p0[uartc_pkg::TX_PIN_POS] & tx_line;
    nxt_st.tx_out  = st_ff.p0oc[uartc_pkg::TX_DRAIN_POS] ? 1'b0 : tx_level;
    nxt_st.tx_oe_n = !st_ff.p0m[uartc_pkg::TX_PIN_POS] ||
                     (st_ff.p0oc[uartc_pkg::TX_DRAIN_POS] && tx_level);

    nxt_st.irq = st_ff.ien[uartc_pkg::GLOBAL_IRQ_POS] && st_ff.ien[uartc_pkg::UART_IRQ_POS] &&
                 (st_ff.scon[uartc_pkg::TX_DONE_POS] || st_ff.scon[uartc_pkg::RX_DONE_POS]);
  end : next_state

  always_ff @(posedge clk or negedge arst_n) begin : state_reg
    if (!arst_n) begin
      st_ff <= uartc_pkg::STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end : state_reg

  assign reg_rdata           = st_ff.rd_data;
  assign serial_out_pin_o    = st_ff.tx_out;
  assign serial_out_pin_oe_n = st_ff.tx_oe_n;
  assign uart_irq            = st_ff.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_disabled_halt: assert property (!en |=> (st_ff.tx_state == uartc_pkg::TX_IDLE) &&
    (st_ff.rx_state == uartc_pkg::RX_IDLE) && (st_ff.presc == 13'h0000))
    else $error("engines run while port disabled");

  a_tx_launch: assert property (buf_wr && (st_ff.tx_state == uartc_pkg::TX_IDLE) |=>
    (st_ff.tx_state == uartc_pkg::TX_START) ##1 !st_ff.tx_out)
    else $error("buffer write did not start a frame");

  a_frame_length: assert property ((st_ff.tx_state == uartc_pkg::TX_DATA) && tx_end &&
    (st_ff.tx_bits == 4'h7) && !nine |=> (st_ff.tx_state == uartc_pkg::TX_STOP))
    else $error("mode 1 frame not eight data bits");

  a_ninth_bit_mode: assert property ((st_ff.tx_state == uartc_pkg::TX_DATA) &&
    (st_ff.tx_bits == 4'h8) |-> nine)
    else $error("ninth data bit sent outside modes 2 and 3");

  a_tx_flag_stop: assert property ($rose(st_ff.tx_state == uartc_pkg::TX_STOP) |->
    st_ff.scon[uartc_pkg::TX_DONE_POS])
    else $error("transmit flag not set at stop bit start");

  a_flag_sticky: assert property ($past(st_ff.scon[uartc_pkg::RX_DONE_POS]) &&
    !$past(bus_req.wr && (bus_req.addr == uartc_pkg::ADDR_SERIAL_CONTROL)) |->
    st_ff.scon[uartc_pkg::RX_DONE_POS])
    else $error("receive flag cleared without a write");

  a_mp_filter: assert property (rx_set |-> !(st_ff.scon[uartc_pkg::MP_EN_POS] && nine &&
    !rx_ninth))
    else $error("receive flag raised for data frame under addressing");

  a_mode2_rate: assert property (tick && (mode == uartc_pkg::MODE2) && !baud_double |->
    (st_ff.presc == 13'h0003))
    else $error("mode 2 tick not every four cycles");

  a_reload_rate: assert property (tick && (mode == uartc_pkg::MODE1) && st_ff.bd && baud_double |->
    (st_ff.presc == 13'(13'h0800 - {2'h0, st_ff.reload, 1'b0} - 13'h0001)))
    else $error("reload tick period wrong");

  a_irq_gate: assert property (uart_irq |-> $past(st_ff.ien[7] && st_ff.ien[4]))
    else $error("interrupt without both enables");

  a_rx_blocked: assert property ((st_ff.rx_state == uartc_pkg::RX_IDLE) &&
    st_ff.p0oc[uartc_pkg::RX_DRAIN_POS] |=> (st_ff.rx_state == uartc_pkg::RX_IDLE))
    else $error("reception started with receive pin drain select set");

  a_latch_low: assert property ($past(!st_ff.p0[5] && st_ff.p0m[5]) |->
    !serial_out_pin_oe_n && !serial_out_pin_o)
    else $error("transmit pin not held low by latch");

  a_open_drain: assert property ($past(st_ff.p0oc[0]) |-> !serial_out_pin_o)
    else $error("open-drain pin driven high");

  a_live_level: assert property (bus_req.rd && (bus_req.addr == 8'h80) |=>
    (reg_rdata[6] == $past(serial_in_pin)))
    else $error("receive pin bit not live");

  a_gated_read: assert property (bus_req.rd && !en && (bus_req.addr == 8'h99) |=>
    (reg_rdata == 8'h00))
    else $error("buffer readable while disabled");

  c_tx_frame: cover property ($fell(st_ff.tx_state == uartc_pkg::TX_STOP));
  c_rx_frame: cover property (rx_set);
  c_rx_nine:  cover property (rx_set && (mode == uartc_pkg::MODE3));
  c_irq:      cover property ($rose(uart_irq));

endmodule : uartc_top

`default_nettype wire
